// *** core/axil_reg_slave.sv ***
// axi4-lite slave front end: handshakes, one write and one read at a time
`default_nettype none
module axil_reg_slave (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // axi4-lite
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // register file side
    output logic             wr_en,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [11:0] addr_q, addr_d;
    logic [31:0] data_q, data_d, rdata_q, rdata_d;
    logic [3:0]  strb_q, strb_d;

    assign wr_en   = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_addr = addr_q;
    assign wr_data = data_q;
    assign wr_strb = strb_q;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        addr_d    = addr_q;
        data_d    = data_q;
        strb_d    = strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        // address and data are taken in either order
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'h1;
            addr_d    = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'h1;
            data_d   = s_axi_wdata;
            strb_d   = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'h0;
        end
        if (wr_en) begin
            aw_held_d = 1'h0;
            w_held_d  = 1'h0;
            bvalid_d  = 1'h1;
            bresp_d   = wr_ok ? link_io_pkg::RESP_OKAY : link_io_pkg::RESP_SLVERR;
        end
        awready_d = ~aw_held_d & ~bvalid_d;
        wready_d  = ~w_held_d & ~bvalid_d;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'h0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'h1;
            rdata_d  = rd_data;
            rresp_d  = rd_ok ? link_io_pkg::RESP_OKAY : link_io_pkg::RESP_SLVERR;
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            aw_held_q <= 1'h0;
            w_held_q  <= 1'h0;
            awready_q <= 1'h1;
            wready_q  <= 1'h1;
            arready_q <= 1'h1;
            bvalid_q  <= 1'h0;
            rvalid_q  <= 1'h0;
            bresp_q   <= link_io_pkg::RESP_OKAY;
            rresp_q   <= link_io_pkg::RESP_OKAY;
            addr_q    <= 12'h000;
            data_q    <= 32'h0000_0000;
            strb_q    <= 4'h0;
            rdata_q   <= 32'h0000_0000;
        end else if (clk_en) begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            addr_q    <= addr_d;
            data_q    <= data_d;
            strb_q    <= strb_d;
            rdata_q   <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
endmodule
`default_nettype wire

// *** core/cyclic_link_io_exchange.sv ***
// master-station cyclic exchange of bit and word buffers with remote stations
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module cyclic_link_io_exchange (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // axi4-lite register bus
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link request toward remote stations
    output logic             link_req,
    output logic             link_kind,
    output logic [1:0]       link_station,
    output logic [2:0]       link_word_idx,
    output logic [31:0]      link_out_bits,
    output logic [15:0]      link_out_word,
    // link answer from remote stations
    input  wire logic        link_rsp_valid,
    input  wire logic [31:0] link_in_bits,
    input  wire logic [15:0] link_in_word,
    // interrupt
    output logic             irq
);
    localparam int unsigned NS = link_io_pkg::NUM_STATIONS;
    localparam int unsigned NW = link_io_pkg::NUM_WORDS;

    logic        wr_en, wr_ok, rd_ok;
    logic [11:0] wr_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0]  wr_strb;

    axil_reg_slave u_bus (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .clk_en        (clk_en),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    //////////////////////////////////////////////////////////////////////////
    // address and byte-strobe merge helpers
    function automatic logic in_area(input logic [11:0] a, input logic [11:0] base,
                                     input int unsigned cnt);
        in_area = (a >= base) && ({20'h0, a} < {20'h0, base} + cnt * 4) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // buffers and control state
    logic [31:0] bit_in_q  [NS];
    logic [31:0] bit_in_d  [NS];
    logic [31:0] bit_out_q [NS];
    logic [31:0] bit_out_d [NS];
    logic [15:0] word_wr_q [NW];
    logic [15:0] word_wr_d [NW];
    logic [15:0] word_rd_q [NW];
    logic [15:0] word_rd_d [NW];

    logic [3:0]  ctrl_q, ctrl_d;
    logic [1:0]  irq_st_q, irq_st_d, irq_en_q, irq_en_d, irq_set;
    logic        irq_q, irq_d;
    logic [15:0] scan_cnt_q, scan_cnt_d;
    logic [10:0] tmo_q, tmo_d;

    link_io_pkg::scan_state_t state_q, state_d;
    logic        req_q, req_d, kind_q, kind_d;
    logic [1:0]  stn_q, stn_d;
    logic [2:0]  widx_q, widx_d;
    logic [31:0] obits_q, obits_d;
    logic [15:0] oword_q, oword_d;

    logic        bit_cap, word_cap;
    logic [4:0]  word_slot;
    logic        running, io_only;
    logic [1:0]  last_stn;

    assign running   = ctrl_q[link_io_pkg::CTRL_START_BIT];
    assign io_only   = ctrl_q[link_io_pkg::CTRL_IO_ONLY_BIT];
    assign last_stn  = ctrl_q[link_io_pkg::CTRL_LAST_LSB +: 2];
    assign word_slot = {stn_q, widx_q};

    // per-station bit slices, fixed by station number
    for (genvar s = 0; s < NS; s++) begin : g_stn
        logic [11:0] ry_addr;
        assign ry_addr = link_io_pkg::BASE_BIT_OUT + 12'(s * 4);
        always_comb begin
            bit_in_d[s]  = bit_in_q[s];
            bit_out_d[s] = bit_out_q[s];
            if (bit_cap && stn_q == 2'(s)) begin
                bit_in_d[s] = link_in_bits;
            end
            if (wr_en && wr_addr == ry_addr) begin
                bit_out_d[s] = merge(bit_out_q[s], wr_data, wr_strb);
            end
        end
        always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
                bit_in_q[s]  <= 32'h0000_0000;
                bit_out_q[s] <= 32'h0000_0000;
            end else if (clk_en) begin
                bit_in_q[s]  <= bit_in_d[s];
                bit_out_q[s] <= bit_out_d[s];
            end
        end
    end

    // per-entry word slices, station-major order
    for (genvar w = 0; w < NW; w++) begin : g_word
        logic [11:0] rw_addr;
        assign rw_addr = link_io_pkg::BASE_WORD_WR + 12'(w * 4);
        always_comb begin
            word_wr_d[w] = word_wr_q[w];
            word_rd_d[w] = word_rd_q[w];
            if (wr_en && wr_addr == rw_addr) begin
                word_wr_d[w] = 16'(merge({16'h0000, word_wr_q[w]}, wr_data,
                                         wr_strb));
            end
            if (word_cap && word_slot == 5'(w)) begin
                word_rd_d[w] = link_in_word;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
                word_wr_q[w] <= 16'h0000;
                word_rd_q[w] <= 16'h0000;
            end else if (clk_en) begin
                word_wr_q[w] <= word_wr_d[w];
                word_rd_q[w] <= word_rd_d[w];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // cyclic scan: bits then, in full mode, the station's words
    always_comb begin
        state_d  = state_q;
        req_d    = req_q;
        kind_d   = kind_q;
        stn_d    = stn_q;
        widx_d   = widx_q;
        obits_d  = obits_q;
        oword_d  = oword_q;
        tmo_d    = tmo_q;
        bit_cap  = 1'h0;
        word_cap = 1'h0;
        irq_set  = 2'h0;
        scan_cnt_d = scan_cnt_q;
        // a lost station must not stall the scan
        if (req_q && !link_rsp_valid) begin
            tmo_d = tmo_q + 11'h001;
        end
        unique case (state_q)
            link_io_pkg::SCAN_IDLE: begin
                stn_d = 2'h0;
                if (running) begin
                    state_d = link_io_pkg::SCAN_BITS;
                end
            end
            link_io_pkg::SCAN_BITS: begin
                if (!req_q) begin
                    req_d   = 1'h1;
                    kind_d  = link_io_pkg::KIND_BITS;
                    obits_d = bit_out_q[stn_q];
                    tmo_d   = 11'h000;
                end else if (link_rsp_valid || tmo_q == 11'(link_io_pkg::LINK_TIMEOUT_CYC)) begin
                    req_d   = 1'h0;
                    bit_cap = link_rsp_valid;
                    irq_set[link_io_pkg::IRQ_TIMEOUT] = ~link_rsp_valid;
                    widx_d  = 3'h0;
                    // io-only mode leaves the word phase out entirely
                    state_d = io_only ? link_io_pkg::SCAN_NEXT
                                      : link_io_pkg::SCAN_WORDS;
                end
            end
            link_io_pkg::SCAN_WORDS: begin
                if (!req_q) begin
                    req_d   = 1'h1;
                    kind_d  = link_io_pkg::KIND_WORD;
                    oword_d = word_wr_q[word_slot];
                    tmo_d   = 11'h000;
                end else if (link_rsp_valid || tmo_q == 11'(link_io_pkg::LINK_TIMEOUT_CYC)) begin
                    req_d    = 1'h0;
                    word_cap = link_rsp_valid;
                    irq_set[link_io_pkg::IRQ_TIMEOUT] = ~link_rsp_valid;
                    widx_d   = widx_q + 3'h1;
                    if (widx_q == 3'(link_io_pkg::WORDS_PER_STN - 1)) begin
                        state_d = link_io_pkg::SCAN_NEXT;
                    end
                end
            end
            link_io_pkg::SCAN_NEXT: begin
                stn_d   = stn_q + 2'h1;
                state_d = link_io_pkg::SCAN_BITS;
                if (stn_q == last_stn) begin
                    stn_d      = 2'h0;
                    scan_cnt_d = scan_cnt_q + 16'h0001;
                    irq_set[link_io_pkg::IRQ_SCAN_DONE] = 1'h1;
                    if (!running) begin
                        state_d = link_io_pkg::SCAN_IDLE;
                    end
                end
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // control, interrupt registers and read decode
    always_comb begin
        ctrl_d   = ctrl_q;
        irq_en_d = irq_en_q;
        if (wr_en && wr_addr == link_io_pkg::ADDR_CTRL && wr_strb[0]) begin
            ctrl_d = wr_data[3:0];
        end
        if (wr_en && wr_addr == link_io_pkg::ADDR_IRQ_ENABLE && wr_strb[0]) begin
            irq_en_d = wr_data[1:0];
        end
        // a new event outranks a clear in the same cycle
        irq_st_d = irq_st_q | irq_set;
        if (wr_en && wr_addr == link_io_pkg::ADDR_IRQ_CLEAR && wr_strb[0]) begin
            irq_st_d = (irq_st_q & ~wr_data[1:0]) | irq_set;
        end
        irq_d = |(irq_st_d & irq_en_d);
    end

    always_comb begin
        wr_ok = (wr_addr == link_io_pkg::ADDR_CTRL) || (wr_addr == link_io_pkg::ADDR_IRQ_CLEAR)
             || (wr_addr == link_io_pkg::ADDR_IRQ_ENABLE)
             || in_area(wr_addr, link_io_pkg::BASE_BIT_OUT, NS)
             || in_area(wr_addr, link_io_pkg::BASE_WORD_WR, NW);
        rd_ok   = 1'h1;
        rd_data = 32'h0000_0000;
        if (s_axi_araddr == link_io_pkg::ADDR_CTRL) begin
            rd_data = {28'h0, ctrl_q};
        end else if (s_axi_araddr == link_io_pkg::ADDR_STATUS) begin
            rd_data = {27'h0, io_only, stn_q, state_q != link_io_pkg::SCAN_IDLE, req_q};
        end else if (s_axi_araddr == link_io_pkg::ADDR_IRQ_STATUS) begin
            rd_data = {30'h0, irq_st_q};
        end else if (s_axi_araddr == link_io_pkg::ADDR_IRQ_CLEAR) begin
            rd_data = 32'h0000_0000;
        end else if (s_axi_araddr == link_io_pkg::ADDR_IRQ_ENABLE) begin
            rd_data = {30'h0, irq_en_q};
        end else if (s_axi_araddr == link_io_pkg::ADDR_SCAN_COUNT) begin
            rd_data = {16'h0, scan_cnt_q};
        end else if (in_area(s_axi_araddr, link_io_pkg::BASE_BIT_IN, NS)) begin
            rd_data = bit_in_q[s_axi_araddr[3:2]];
        end else if (in_area(s_axi_araddr, link_io_pkg::BASE_BIT_OUT, NS)) begin
            rd_data = bit_out_q[s_axi_araddr[3:2]];
        end else if (in_area(s_axi_araddr, link_io_pkg::BASE_WORD_WR, NW)) begin
            rd_data = {16'h0, word_wr_q[s_axi_araddr[6:2]]};
        end else if (in_area(s_axi_araddr, link_io_pkg::BASE_WORD_RD, NW)) begin
            rd_data = {16'h0, word_rd_q[s_axi_araddr[6:2]]};
        end else begin
            rd_ok = 1'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q    <= link_io_pkg::SCAN_IDLE;
            req_q      <= 1'h0;
            kind_q     <= link_io_pkg::KIND_BITS;
            stn_q      <= 2'h0;
            widx_q     <= 3'h0;
            obits_q    <= 32'h0000_0000;
            oword_q    <= 16'h0000;
            tmo_q      <= 11'h000;
            scan_cnt_q <= 16'h0000;
            ctrl_q     <= link_io_pkg::CTRL_RESET;
            irq_st_q   <= link_io_pkg::IRQ_RESET;
            irq_en_q   <= link_io_pkg::IRQ_RESET;
            irq_q      <= 1'h0;
        end else if (clk_en) begin
            state_q    <= state_d;
            req_q      <= req_d;
            kind_q     <= kind_d;
            stn_q      <= stn_d;
            widx_q     <= widx_d;
            obits_q    <= obits_d;
            oword_q    <= oword_d;
            tmo_q      <= tmo_d;
            scan_cnt_q <= scan_cnt_d;
            ctrl_q     <= ctrl_d;
            irq_st_q   <= irq_st_d;
            irq_en_q   <= irq_en_d;
            irq_q      <= irq_d;
        end
    end

    assign link_req      = req_q;
    assign link_kind     = kind_q;
    assign link_station  = stn_q;
    assign link_word_idx = widx_q;
    assign link_out_bits = obits_q;
    assign link_out_word = oword_q;
    assign irq           = irq_q;
endmodule
`default_nettype wire

// *** include/link_io_pkg.sv ***
// constants, address map and state codes of the cyclic link exchange block
`default_nettype none
package link_io_pkg;
    // buffer geometry
    localparam int unsigned NUM_STATIONS  = 4;
    localparam int unsigned WORDS_PER_STN = 8;
    localparam int unsigned NUM_WORDS     = NUM_STATIONS * WORDS_PER_STN;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;
    localparam logic [11:0] ADDR_SCAN_COUNT = 12'h014;
    localparam logic [11:0] BASE_BIT_IN     = 12'h100;
    localparam logic [11:0] BASE_BIT_OUT    = 12'h180;
    localparam logic [11:0] BASE_WORD_WR    = 12'h200;
    localparam logic [11:0] BASE_WORD_RD    = 12'h300;

    // ctrl fields
    localparam int unsigned CTRL_START_BIT   = 0;
    localparam int unsigned CTRL_IO_ONLY_BIT = 1;
    localparam int unsigned CTRL_LAST_LSB    = 2;
    localparam logic [3:0]  CTRL_RESET       = 4'h0;

    // interrupt status layout
    localparam int unsigned IRQ_SCAN_DONE = 0;
    localparam int unsigned IRQ_TIMEOUT   = 1;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // link item kinds
    localparam logic KIND_BITS = 1'h0;
    localparam logic KIND_WORD = 1'h1;

    // station answer timeout
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned LINK_TIMEOUT_NS = 10000;
    localparam int unsigned LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SCAN_IDLE  = 2'h0,
        SCAN_BITS  = 2'h1,
        SCAN_WORDS = 2'h3,
        SCAN_NEXT  = 2'h2
    } scan_state_t;
endpackage
`default_nettype wire

// *** tb/cyclic_link_io_exchange_properties.sv ***
// link item and register bus handshake checks
`default_nettype none
module cyclic_link_io_exchange_properties (
    input wire logic sys_clk, reset_n, link_req, link_rsp_valid, link_kind,
    input wire logic [2:0] link_word_idx,
    input wire logic [31:0] link_out_bits, s_axi_rdata,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence item_wait; link_req && !link_rsp_valid; endsequence
    sequence item_done; link_req && link_rsp_valid; endsequence
    sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    a_item_holds: assert property (item_wait |=> link_req) else $error("item dropped");
    a_payload_steady: assert property (item_wait |=> $stable(link_out_bits) && $stable(link_kind))
        else $error("payload moved");
    a_item_gap: assert property (item_done |=> !link_req) else $error("no gap");
    a_word_next: assert property (item_done ##0 (link_kind && link_word_idx != 3'h7) |=> ##1
        (link_req && link_kind && link_word_idx == $past(link_word_idx, 2) + 3'h1))
        else $error("word order");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read dropped");
    a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid) else $error("write late");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
endmodule
bind cyclic_link_io_exchange cyclic_link_io_exchange_properties i_props (.*);
`default_nettype wire

// *** tb/remote_station_model.sv ***
// remote stations answering link items, promptly or slowly
`default_nettype none
module remote_station_model (
    input wire logic sys_clk, reset_n, slow, link_req, link_kind,
    input wire logic [1:0] link_station,
    input wire logic [2:0] link_word_idx,
    input wire logic [31:0] link_out_bits,
    input wire logic [15:0] link_out_word,
    output logic link_rsp_valid,
    output logic [31:0] link_in_bits,
    output logic [15:0] link_in_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] seen_bits [4];
    logic [15:0] seen_word [32];
    int wait_q, word_cnt;
    always @(posedge sys_clk) begin
        link_rsp_valid <= 1'b0;
        // released lines toggle so a stale sample never matches
        link_in_bits <= ~link_in_bits;
        link_in_word <= ~link_in_word;
        if (!reset_n) begin
            {wait_q, word_cnt, link_in_bits, link_in_word} <= '0;
        end else if (link_req && !link_rsp_valid) begin
            if (wait_q < (slow ? 5 : 0)) begin
                wait_q <= wait_q + 1;
            end else begin
                wait_q <= 0;
                link_rsp_valid <= 1'b1;
                link_in_bits <= 32'h0f00000f | {22'h0, link_station, 8'h00};
                link_in_word <= 16'ha000 | {11'h0, link_station, link_word_idx};
                if (link_kind) begin
                    seen_word[{link_station, link_word_idx}] <= link_out_word;
                    word_cnt <= word_cnt + 1;
                end else begin
                    seen_bits[link_station] <= link_out_bits;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_cyclic_link_io_exchange.sv ***
// register-level test of the cyclic link exchange
`default_nettype none
module test_cyclic_link_io_exchange;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0, irq;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, link_station;
    logic link_req, link_kind, link_rsp_valid;
    logic [2:0] link_word_idx;
    logic [31:0] link_out_bits, link_in_bits;
    logic [15:0] link_out_word, link_in_word;
    int fail_count = 0, total_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    cyclic_link_io_exchange i_dut (.sys_clk, .reset_n, .clk_en(1'b1), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .link_req, .link_kind, .link_station, .link_word_idx, .link_out_bits,
        .link_out_word, .link_rsp_valid, .link_in_bits, .link_in_word, .irq);
    remote_station_model i_model (.sys_clk, .reset_n, .slow, .link_req, .link_kind,
        .link_station, .link_word_idx, .link_out_bits, .link_out_word, .link_rsp_valid,
        .link_in_bits, .link_in_word);
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 400) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic aw, w, b;
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge sys_clk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge sys_clk);
            n++;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b && n < 400);
        s_axi_bready <= 1'b0;
        guard(n);
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar, rv;
        int n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge sys_clk);
            {ar, rv, v, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge sys_clk);
            n++;
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!rv && n < 400);
        s_axi_rready <= 1'b0;
        guard(n);
        @(posedge sys_clk);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge sys_clk);
        guard(n);
    endtask
    initial begin
        logic [1:0] r;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(link_io_pkg::ADDR_CTRL, d, r);
        chk("ctrl reset", d, 32'h0);
        rd(12'hffc, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, link_io_pkg::RESP_SLVERR});
        wr(12'h184, 32'h07000003);
        for (int w = 0; w < 7; w++) wr(12'h220 + 12'(4 * w), 32'h1000 + w);
        rd(12'h220, d, r);
        chk("word write", d, 32'h1000);
        wr(link_io_pkg::ADDR_IRQ_ENABLE, 32'h1);
        wr(link_io_pkg::ADDR_CTRL, 32'hd);
        wait_irq();
        rd(12'h104, d, r);
        chk("bit in", d, 32'h0f00010f);
        rd(12'h328, d, r);
        chk("word read", d, 32'h0000a00a);
        chk("bits sent", i_model.seen_bits[1], 32'h07000003);
        for (int w = 0; w < 7; w++) chk("word sent", 32'(i_model.seen_word[8 + w]), 32'h1000 + w);
        chk("full mode words", 32'(i_model.word_cnt >= 32), 32'h1);
        wr(link_io_pkg::ADDR_CTRL, 32'h0);
        d = '1;
        for (int n = 0; n < 50 && d[1] !== 1'b0; n++) rd(link_io_pkg::ADDR_STATUS, d, r);
        chk("scan stop", {31'h0, d[1]}, 32'h0);
        chk("irq raised", 32'(irq), 32'h1);
        wr(link_io_pkg::ADDR_IRQ_ENABLE, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        wr(link_io_pkg::ADDR_IRQ_CLEAR, 32'h1);
        rd(link_io_pkg::ADDR_IRQ_STATUS, d, r);
        chk("irq cleared", d, 32'h0);
        wr(link_io_pkg::ADDR_IRQ_ENABLE, 32'h1);
        d = i_model.word_cnt;
        slow <= 1'b1;
        wr(link_io_pkg::ADDR_CTRL, 32'h3);
        wait_irq();
        wr(link_io_pkg::ADDR_CTRL, 32'h2);
        chk("io mode words", i_model.word_cnt, d);
        summarize();
    end
endmodule
`default_nettype wire
